// ===== hdl/supply_monitor_reset_control.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.svh"

// How it works
// (R01) Power-on clear zeroes all reset cause flags.
// (R02) Byte write of zero to mode stops detection.
// (R03) Clearing the enable bit alone stops detection.
// (R04) Software writes zero to mode bits two-six.
// (R05) Software writes zero to level bits four-seven.
// (R06) Stop detection before changing the threshold level.
// (R07) No reset while supply is above threshold.
// (R08) Clear interrupt mask lets drop interrupts through.
// (R09) Enabled drop raises reset in reset mode, and the drop interrupt in either mode.
module smr_supply_monitor_reset_control (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire smr_pkg::smr_word_t s_axi_awaddr,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire smr_pkg::smr_word_t s_axi_wdata,
    input  wire smr_pkg::smr_strb_t s_axi_wstrb,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output logic [1:0]              s_axi_bresp,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire smr_pkg::smr_word_t s_axi_araddr,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output smr_pkg::smr_word_t      s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    input  wire logic               powerOnClear,
    input  wire logic               supplyBelow,
    output logic [3:0]              thresholdSel,
    output logic                    internalReset,
    output logic                    irq
);
    import smr_pkg::*;

    smr_state_t             r;
    smr_state_t             st_nxt;
    logic [`SMR_SYNC_W-1:0] syncLvl;
    logic                   pocNow;
    logic                   belowNow;
    logic                   doWrite;
    logic                   wrOk;
    logic [7:0]             d;
    logic                   dropEdge;

    // =================================================================
    // Pin inputs cross into the clock domain.
    smr_sync3 u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({supplyBelow, powerOnClear}),
        .syncOut (syncLvl)
    );

    assign pocNow   = syncLvl[`SMR_SYNC_POC];
    assign belowNow = syncLvl[`SMR_SYNC_BELOW];

    // =================================================================
    // Next state.
    always_comb begin
        st_nxt   = r;
        doWrite  = 1'b0;
        wrOk     = 1'b1;
        d        = 8'h00;
        dropEdge = 1'b0;

        // Write address and data are taken in either order.
        if (s_axi_awvalid && r.awRdy) begin
            st_nxt.awHave = 1'b1;
            st_nxt.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && r.wRdy) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = s_axi_wdata[7:0];
            st_nxt.wLane = s_axi_wstrb[0];
        end
        if (r.bValid && s_axi_bready) begin
            st_nxt.bValid = 1'b0;
        end

        // Only byte lane zero carries register bits.
        if (st_nxt.awHave && st_nxt.wHave && !r.bValid) begin
            doWrite       = 1'b1;
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bValid = 1'b1;
        end
        d = st_nxt.wData;

        if (doWrite) begin
            case (st_nxt.awAddr)
                `SMR_OFS_MODE: begin
                    if (st_nxt.wLane) begin
                        // Reserved bits are dropped and read as zero.
                        st_nxt.detEnable = d[`SMR_MODE_EN_BIT];  // [R02] [R04]
                        st_nxt.resetMode = d[`SMR_MODE_RST_BIT];
                    end
                end
                `SMR_OFS_MCLR: begin
                    if (st_nxt.wLane && d[`SMR_MODE_EN_BIT]) begin
                        st_nxt.detEnable = 1'b0;  // [R03]
                    end
                    if (st_nxt.wLane && d[`SMR_MODE_RST_BIT]) begin
                        st_nxt.resetMode = 1'b0;
                    end
                end
                `SMR_OFS_LEVEL: begin
                    // A write during detection is not guarded: the new
                    // level takes effect at once, so the comparator may
                    // see a glitch; stopping first is up to software.
                    if (st_nxt.wLane) begin
                        st_nxt.level = d[`SMR_LEVEL_W-1:0];  // [R05] [R06]
                    end
                end
                `SMR_OFS_ICLR: begin
                    if (st_nxt.wLane) begin
                        st_nxt.intStat = r.intStat & ~d[`SMR_EV_W-1:0];
                    end
                end
                `SMR_OFS_IEN: begin
                    if (st_nxt.wLane) begin
                        st_nxt.intEn = d[`SMR_EV_W-1:0];
                    end
                end
                `SMR_OFS_MASK: begin
                    if (st_nxt.wLane) begin
                        st_nxt.intMask = d[0];
                    end
                end
                `SMR_OFS_CAUSE,
                `SMR_OFS_ISTAT: begin
                    wrOk = 1'b1;
                end
                default: begin
                    wrOk = 1'b0;
                end
            endcase
            st_nxt.bResp = wrOk ? `SMR_RESP_OKAY : `SMR_RESP_SLVERR;
        end
        // Both channels stay closed while a response waits for bready.
        st_nxt.awRdy = !st_nxt.awHave && !st_nxt.bValid;
        st_nxt.wRdy  = !st_nxt.wHave && !st_nxt.bValid;

        // Read channel: one read at a time, data one edge after address.
        if (r.rValid && s_axi_rready) begin
            st_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && r.arRdy) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp  = `SMR_RESP_OKAY;
            st_nxt.rData  = `SMR_WORD_ZERO;
            case (s_axi_araddr[7:0])
                `SMR_OFS_MODE: begin
                    st_nxt.rData[`SMR_MODE_EN_BIT]   = r.detEnable;
                    st_nxt.rData[`SMR_MODE_RST_BIT]  = r.resetMode;
                    st_nxt.rData[`SMR_MODE_FLAG_BIT] = r.belowSeen;
                end
                `SMR_OFS_LEVEL: begin
                    st_nxt.rData[`SMR_LEVEL_W-1:0] = r.level;
                end
                `SMR_OFS_CAUSE: begin
                    st_nxt.rData[`SMR_EV_W-1:0] = r.cause;
                end
                `SMR_OFS_ISTAT: begin
                    st_nxt.rData[`SMR_EV_W-1:0] = r.intStat;
                end
                `SMR_OFS_IEN: begin
                    st_nxt.rData[`SMR_EV_W-1:0] = r.intEn;
                end
                `SMR_OFS_MASK: begin
                    st_nxt.rData[0] = r.intMask;
                end
                `SMR_OFS_ICLR,
                `SMR_OFS_MCLR: begin
                    st_nxt.rResp = `SMR_RESP_OKAY;
                end
                default: begin
                    st_nxt.rResp = `SMR_RESP_SLVERR;
                end
            endcase
        end
        st_nxt.arRdy = !st_nxt.rValid;

        // =============================================================
        // Detector. Events are applied after the clear register, so a
        // set in the same cycle as its clear is kept.
        dropEdge         = r.detEnable && belowNow && !r.belowSeen;
        st_nxt.belowSeen = r.detEnable && belowNow;
        st_nxt.intReset  = r.detEnable && r.resetMode && belowNow;  // [R07] [R09]
        if (dropEdge && !r.intMask) begin
            st_nxt.intStat[`SMR_EV_DROP] = 1'b1;  // [R08] [R09]
        end
        if (st_nxt.intReset && !r.intReset) begin
            st_nxt.cause[`SMR_CAUSE_DET_BIT] = 1'b1;
            st_nxt.intStat[`SMR_EV_RST]      = 1'b1;
        end

        // Power-on clear outranks mode, level and cause updates, including new causes; interrupt registers are not touched.
        if (pocNow) begin
            st_nxt.cause     = '0;  // [R01]
            st_nxt.detEnable = 1'b0;
            st_nxt.resetMode = 1'b0;
            st_nxt.level     = '0;
            st_nxt.belowSeen = 1'b0;
            st_nxt.intReset  = 1'b0;
        end

        st_nxt.irq = |(st_nxt.intStat & st_nxt.intEn);
    end

    // =================================================================
    // State register.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r         <= '0;
            r.awRdy   <= 1'b1;
            r.wRdy    <= 1'b1;
            r.arRdy   <= 1'b1;
            r.intMask <= `SMR_MASK_RST;
        end else begin
            r <= st_nxt;
        end
    end

    // =================================================================
    // Outputs, all straight from the state register.
    assign s_axi_awready = r.awRdy;
    assign s_axi_wready  = r.wRdy;
    assign s_axi_bvalid  = r.bValid;
    assign s_axi_bresp   = r.bResp;
    assign s_axi_arready = r.arRdy;
    assign s_axi_rvalid  = r.rValid;
    assign s_axi_rdata   = r.rData;
    assign s_axi_rresp   = r.rResp;
    assign thresholdSel  = r.level;
    assign internalReset = r.intReset;
    assign irq           = r.irq;

endmodule : smr_supply_monitor_reset_control

`default_nettype wire

// ===== inc/smr_consts.svh
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH

// =====================================================================
// Register offsets (byte addresses, low eight address bits decoded).
`define SMR_OFS_MODE      8'h00
`define SMR_OFS_LEVEL     8'h04
`define SMR_OFS_CAUSE     8'h08
`define SMR_OFS_ISTAT     8'h0C
`define SMR_OFS_ICLR      8'h10
`define SMR_OFS_IEN       8'h14
`define SMR_OFS_MASK      8'h18
`define SMR_OFS_MCLR      8'h1C

// =====================================================================
// Field positions.
`define SMR_MODE_EN_BIT   7
`define SMR_MODE_RST_BIT  1
`define SMR_MODE_FLAG_BIT 0
`define SMR_EV_DROP       0
`define SMR_EV_RST        1
`define SMR_CAUSE_DET_BIT 0

// =====================================================================
// Widths, reset values and bus answers.
`define SMR_LEVEL_W       4
`define SMR_EV_W          2
`define SMR_SYNC_W        2
`define SMR_SYNC_POC      0
`define SMR_SYNC_BELOW    1
`define SMR_MASK_RST      1'h1
`define SMR_RESP_OKAY     2'h0
`define SMR_RESP_SLVERR   2'h2
`define SMR_WORD_ZERO     32'h0000_0000

`endif

// ===== inc/smr_pkg.sv
`include "smr_consts.svh"

package smr_pkg;

    typedef logic [31:0] smr_word_t;
    typedef logic [3:0]  smr_strb_t;

    typedef struct packed {
        logic [`SMR_SYNC_W-1:0] s1;
        logic [`SMR_SYNC_W-1:0] s2;
        logic [`SMR_SYNC_W-1:0] s3;
        logic [`SMR_SYNC_W-1:0] level;
    } smr_sync_t;

    typedef struct packed {
        logic                    awRdy;
        logic                    awHave;
        logic [7:0]              awAddr;
        logic                    wRdy;
        logic                    wHave;
        logic [7:0]              wData;
        logic                    wLane;
        logic                    bValid;
        logic [1:0]              bResp;
        logic                    arRdy;
        logic                    rValid;
        smr_word_t               rData;
        logic [1:0]              rResp;
        logic                    detEnable;
        logic                    resetMode;
        logic [`SMR_LEVEL_W-1:0] level;
        logic [`SMR_EV_W-1:0]    cause;
        logic [`SMR_EV_W-1:0]    intStat;
        logic [`SMR_EV_W-1:0]    intEn;
        logic                    intMask;
        logic                    belowSeen;
        logic                    intReset;
        logic                    irq;
    } smr_state_t;

endpackage : smr_pkg

// ===== hdl/smr_sync3.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.svh"

module smr_sync3 (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic [`SMR_SYNC_W-1:0] asyncIn,
    output logic      [`SMR_SYNC_W-1:0] syncOut
);
    import smr_pkg::*;

    smr_sync_t r;
    smr_sync_t st_nxt;

    // =================================================================
    // Three stages; a change is taken once stages two and three agree.
    always_comb begin
        st_nxt    = r;
        st_nxt.s1 = asyncIn;
        st_nxt.s2 = r.s1;
        st_nxt.s3 = r.s2;
        for (int i = 0; i < `SMR_SYNC_W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                st_nxt.level[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= st_nxt;
        end
    end

    assign syncOut = r.level;

endmodule : smr_sync3

`default_nettype wire

// ===== testbench/smr_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none

module smr_monitor_properties (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       powerOnClear,
    input wire logic       supplyBelow,
    input wire logic [3:0] thresholdSel,
    input wire logic       internalReset,
    input wire logic       irq
);
    // =================================================================
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_poc_drops_reset: assert property (
        $rose(powerOnClear) |-> ##5 !internalReset)
        else $error("reset request survived power-on clear");
    chk_poc_level_zero: assert property (
        powerOnClear [*6] |-> thresholdSel == 4'h0)
        else $error("threshold kept through power-on clear");
    chk_no_reset_above: assert property (
        !supplyBelow [*6] |-> !internalReset)
        else $error("reset request while supply is above threshold");
    chk_outputs_quiet: assert property (
        $fell(sys_rst) |-> !irq && !internalReset && thresholdSel == 4'h0)
        else $error("outputs active after reset");
    chk_bvalid_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    chk_read_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_write_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");

    cover property ($rose(internalReset));
    cover property ($rose(irq));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : smr_monitor_properties

`default_nettype wire

// ===== testbench/smr_supply_monitor_reset_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.svh"

module smr_supply_monitor_reset_control_test;
    import smr_pkg::*;
    logic       ref_clk, sys_rst, powerOnClear, supplyBelow;
    logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic       s_axi_rvalid, s_axi_rready, internalReset, irq;
    smr_word_t  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    smr_strb_t  s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] thresholdSel;
    int         miscompares, comparisons;

    smr_supply_monitor_reset_control DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .powerOnClear(powerOnClear),
        .supplyBelow(supplyBelow), .thresholdSel(thresholdSel),
        .internalReset(internalReset), .irq(irq)
    );

    // =================================================================
    // Reporting.
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string w, input smr_word_t e, smr_word_t g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask : check

    task automatic pin(input string w, input logic [3:0] e, logic [3:0] g);
        check(w, {28'h0, e}, {28'h0, g});
    endtask : pin

    // A hung bus must end the run rather than stall it.
    task automatic timeout();
        miscompares++;
        $display("ERROR bus answer expected within bound seen none");
        tally_and_finish();
    endtask : timeout

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // =================================================================
    // Register bus master.
    task automatic wr(input logic [7:0] a, logic [7:0] d, logic [1:0] er);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 20) timeout();
        s_axi_bready <= 1'b0;
        pin("bresp", {2'b0, er}, {2'b0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [7:0] a, logic [7:0] e, logic [1:0] er);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 20) timeout();
        s_axi_rready <= 1'b0;
        check("rdata", {24'h00_0000, e}, s_axi_rdata);
        pin("rresp", {2'b0, er}, {2'b0, s_axi_rresp});
    endtask : rd

    // =================================================================
    // Stimulus.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        sys_rst = 1'b1;
        {powerOnClear, supplyBelow, s_axi_awvalid, s_axi_wvalid} = 4'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'h1;
        miscompares = 0;
        comparisons = 0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`SMR_OFS_MODE, 8'h00, 2'h0);
        rd(`SMR_OFS_MASK, 8'h01, 2'h0);
        rd(8'h20, 8'h00, 2'h2);
        wr(8'h20, 8'h55, 2'h2);
        wr(`SMR_OFS_LEVEL, 8'h05, 2'h0);
        rd(`SMR_OFS_LEVEL, 8'h05, 2'h0);
        pin("thresholdSel", 4'h5, thresholdSel);
        wr(`SMR_OFS_MASK, 8'h00, 2'h0);
        wr(`SMR_OFS_IEN, 8'h01, 2'h0);
        wr(`SMR_OFS_MODE, 8'h80, 2'h0);
        supplyBelow <= 1'b1;
        idle(8);
        pin("irq", 4'h1, irq);
        pin("internalReset", 4'h0, internalReset);
        rd(`SMR_OFS_MODE, 8'h81, 2'h0);
        rd(`SMR_OFS_ISTAT, 8'h01, 2'h0);
        wr(`SMR_OFS_IEN, 8'h00, 2'h0);
        idle(2);
        pin("irq", 4'h0, irq);
        wr(`SMR_OFS_IEN, 8'h01, 2'h0);
        idle(2);
        pin("irq", 4'h1, irq);
        wr(`SMR_OFS_ICLR, 8'h01, 2'h0);
        idle(2);
        pin("irq", 4'h0, irq);
        wr(`SMR_OFS_MODE, 8'h00, 2'h0);
        rd(`SMR_OFS_MODE, 8'h00, 2'h0);
        wr(`SMR_OFS_MODE, 8'h82, 2'h0);
        idle(8);
        pin("internalReset", 4'h1, internalReset);
        rd(`SMR_OFS_CAUSE, 8'h01, 2'h0);
        rd(`SMR_OFS_ISTAT, 8'h03, 2'h0);
        wr(`SMR_OFS_MCLR, 8'h80, 2'h0);
        idle(2);
        pin("internalReset", 4'h0, internalReset);
        rd(`SMR_OFS_MODE, 8'h02, 2'h0);
        supplyBelow <= 1'b0;
        idle(6);
        wr(`SMR_OFS_MODE, 8'h82, 2'h0);
        idle(8);
        pin("internalReset", 4'h0, internalReset);
        supplyBelow <= 1'b1;
        idle(8);
        pin("internalReset", 4'h1, internalReset);
        powerOnClear <= 1'b1;
        idle(8);
        powerOnClear <= 1'b0;
        pin("internalReset", 4'h0, internalReset);
        rd(`SMR_OFS_CAUSE, 8'h00, 2'h0);
        rd(`SMR_OFS_MODE, 8'h00, 2'h0);
        pin("thresholdSel", 4'h0, thresholdSel);
        wr(`SMR_OFS_MASK, 8'h01, 2'h0);
        wr(`SMR_OFS_ICLR, 8'h03, 2'h0);
        wr(`SMR_OFS_MODE, 8'h80, 2'h0);
        idle(4);
        pin("irq", 4'h0, irq);
        rd(`SMR_OFS_ISTAT, 8'h00, 2'h0);
        rd(`SMR_OFS_MODE, 8'h81, 2'h0);
        wr(`SMR_OFS_MODE, 8'h02, 2'h0);
        wr(`SMR_OFS_MCLR, 8'h02, 2'h0);
        rd(`SMR_OFS_MODE, 8'h00, 2'h0);
        s_axi_wstrb <= 4'h0;
        wr(`SMR_OFS_LEVEL, 8'h09, 2'h0);
        s_axi_wstrb <= 4'h1;
        rd(`SMR_OFS_LEVEL, 8'h00, 2'h0);
        wr(`SMR_OFS_CAUSE, 8'h01, 2'h0);
        rd(`SMR_OFS_CAUSE, 8'h00, 2'h0);
        rd(`SMR_OFS_ICLR, 8'h00, 2'h0);
        wr(`SMR_OFS_LEVEL, 8'h03, 2'h0);
        pin("thresholdSel", 4'h3, thresholdSel);
        wr(`SMR_OFS_MASK, 8'h00, 2'h0);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        pin("thresholdSel", 4'h0, thresholdSel);
        rd(`SMR_OFS_MASK, 8'h01, 2'h0);
        rd(`SMR_OFS_LEVEL, 8'h00, 2'h0);
        tally_and_finish();
    end
endmodule : smr_supply_monitor_reset_control_test

bind smr_supply_monitor_reset_control smr_monitor_properties CHK (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .powerOnClear(powerOnClear),
    .supplyBelow(supplyBelow), .thresholdSel(thresholdSel),
    .internalReset(internalReset), .irq(irq)
);

`default_nettype wire
